// ### include/nv_pkg.sv
// constants shared by the nonvolatile access block and its store
package nv_pkg;
   // ===========================================================
   // register offsets on the bus (byte addresses)
   localparam logic [7:0] OFS_ADDR = 8'h00; // nv_addr_reg
   localparam logic [7:0] OFS_DATA = 8'h04; // nv_data_reg
   localparam logic [7:0] OFS_BANK = 8'h08; // bank_select
   localparam logic [7:0] OFS_PTR = 8'h0C; // indirect_pointer
   localparam logic [7:0] OFS_PORT = 8'h10; // indirect_access_port
   localparam logic [7:0] OFS_IRQ_EN = 8'h14; // interrupt enables
   localparam logic [7:0] OFS_IRQ_FLAG = 8'h18; // interrupt flags
   // ===========================================================
   // indirect location of nv_ctrl_reg
   localparam logic [7:0] CTRL_PTR_VAL = 8'h40; // pointer value
   localparam logic [7:0] CTRL_BANK_VAL = 8'h01; // bank value
   // ===========================================================
   // field positions
   localparam int BIT_RD = 0; // read strobe
   localparam int BIT_READ_ALLOW = 1; // read_allow
   localparam int BIT_WR = 2; // write strobe
   localparam int BIT_WRITE_ALLOW = 3; // write_allow
   localparam int EN_NV = 0; // nv_irq_allow
   localparam int EN_MF = 1; // multi-function enable
   localparam int EN_GLB = 2; // global_irq_allow
   localparam int FLAG_NV = 0; // nv_irq_flag
   localparam int FLAG_MF = 1; // multi-function flag
   // ===========================================================
   // sizes and reset values
   localparam int NV_AW = 6; // 64 byte locations
   localparam int NV_DW = 8; // byte wide
   localparam logic [7:0] RST_BYTE = 8'h00; // all registers clear
   // ===========================================================
   // timing
   localparam int CLK_PERIOD_NS = 10; // pclk at 100 MHz
   localparam int READ_TIME_NS = 20; // array access time
   localparam int READ_CYCLES =
      (READ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WRITE_TIME_NS = 2000; // programming time
   localparam int WRITE_CYCLES =
      (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// ### include/nv_mem_if.sv
// link between the access control logic and the byte store
`timescale 1ns/1ns
`default_nettype none
interface nv_mem_if #(parameter int AW = 6, parameter int DW = 8);
   logic rd_go; // start a read, one cycle
   logic wr_go; // start a write, one cycle
   logic [AW-1:0] addr; // byte address, taken at go
   logic [DW-1:0] wdata; // byte to store, taken at go
   logic [DW-1:0] rdata; // fetched byte
   logic rd_done; // read finished, one cycle
   logic wr_done; // write finished, one cycle
   logic busy; // a cycle is running
   modport ctrl (output rd_go, wr_go, addr, wdata,
      input rdata, rd_done, wr_done, busy);
   modport mem (input rd_go, wr_go, addr, wdata,
      output rdata, rd_done, wr_done, busy);
endinterface
`default_nettype wire

// ### core/nv_store.sv
// byte array with read and write cycle timers
`timescale 1ns/1ns
`default_nettype none
module nv_store
   import nv_pkg::*;
#(
   parameter int DEPTH = 64,
   parameter int RD_CYC = READ_CYCLES,
   parameter int WR_CYC = WRITE_CYCLES
)
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // control side
   nv_mem_if.mem m
);
   typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} st_t;
   // ===========================================================
   // state
   logic [NV_DW-1:0] cells [DEPTH]; // storage
   st_t st, next_st; // cycle state
   logic [15:0] cnt, next_cnt; // cycle timer
   logic [NV_AW-1:0] a, next_a; // latched address
   logic [NV_DW-1:0] wd, next_wd; // latched write byte
   logic [NV_DW-1:0] rd, next_rd; // fetched byte
   logic rdone, next_rdone; // read end pulse
   logic wdone, next_wdone; // write end pulse
   // ===========================================================
   // next state: the write timer counts on its own, bus traffic
   // does not stretch or shorten it
   always_comb
   begin
      next_st = st;
      next_cnt = cnt;
      next_a = a;
      next_wd = wd;
      next_rd = rd;
      next_rdone = 1'b0;
      next_wdone = 1'b0;
      unique case (st)
         ST_IDLE:
         begin
            next_cnt = 16'h0000;
            next_a = m.addr;
            next_wd = m.wdata;
            if (m.rd_go)
               next_st = ST_READ;
            else if (m.wr_go)
               next_st = ST_WRITE;
         end
         ST_READ:
         begin
            next_cnt = cnt + 16'h0001;
            if (cnt == 16'(RD_CYC - 1))
            begin
               next_rd = cells[a];
               next_rdone = 1'b1;
               next_st = ST_IDLE;
            end
         end
         ST_WRITE:
         begin
            next_cnt = cnt + 16'h0001;
            if (cnt == 16'(WR_CYC - 1))
            begin
               next_wdone = 1'b1;
               next_st = ST_IDLE;
            end
         end
      endcase
   end
   // ===========================================================
   // registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st <= ST_IDLE;
         cnt <= 16'h0000;
         a <= '0;
         wd <= '0;
         rd <= '0;
         rdone <= 1'b0;
         wdone <= 1'b0;
      end
      else
      begin
         st <= next_st;
         cnt <= next_cnt;
         a <= next_a;
         wd <= next_wd;
         rd <= next_rd;
         rdone <= next_rdone;
         wdone <= next_wdone;
      end
   end
   // ===========================================================
   // array: cells take the byte as the write cycle ends
   always_ff @(posedge pclk)
   begin
      if (st == ST_WRITE && cnt == 16'(WR_CYC - 1))
         cells[a] <= wd;
   end
   assign m.rdata = rd;
   assign m.rd_done = rdone;
   assign m.wr_done = wdone;
   assign m.busy = (st != ST_IDLE);
endmodule // nv_store
`default_nettype wire

// ### core/nv_access_ctrl.sv
// bus registers and control for byte access to the data store
//
// Contract
// (R1) read strobe starts read, clears when done
// (R2) read strobe ignored without read_allow set
// (R3) software never sets both strobes together
// (R4) software sets read_allow, address, then strobe
// (R5) fetched byte held in data register
// (R6) software loads address and data first
// (R7) write strobe follows write_allow immediately
// (R8) write strobe ignored without write_allow set
// (R9) write timed by independent internal timer
// (R10) write strobe clears at write end
// (R11) reset clears write_allow
// (R12) reset clears bank_select to first bank
// (R13) write end sets nv and mf flags
// (R14) interrupt needs all three enables set
// (R15) service clears mf flag only
// (R16) software masks interrupts around write start
// (R17) control reached via pointer and bank
// (R18) software keeps write_allow and bank clear
// (R19) six-bit address, upper bits read zero
// (R20) control bit layout, upper bits zero
// (R21) read bounded, strobes blocked while busy
//
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module nv_access_ctrl
   import nv_pkg::*;
#(
   parameter int DEPTH = 64,
   parameter int WR_CYC = WRITE_CYCLES
)
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // interrupt
   input wire logic irq_ack,
   output logic irq_req
);
   // ===========================================================
   // state
   logic [NV_AW-1:0] nv_addr_reg, next_addr; // byte address
   logic [NV_DW-1:0] nv_data_reg, next_data; // byte data
   logic [7:0] bank_select, next_bank; // bank selector
   logic [7:0] indirect_pointer, next_ptr; // indirect pointer
   logic write_allow, next_write_allow; // write enable
   logic wr_strobe, next_wr; // write running
   logic read_allow, next_read_allow; // read enable
   logic rd_strobe, next_rd; // read running
   logic nv_irq_allow, next_nv_en; // nv interrupt enable
   logic mf_irq_allow, next_mf_en; // multi-function enable
   logic global_irq_allow, next_glb; // global enable
   logic nv_irq_flag, next_nv_flag; // nv request
   logic mf_irq_flag, next_mf_flag; // multi-function request
   logic [31:0] next_prdata; // read data for the access
   // ===========================================================
   // decode
   logic wr_acc; // write access phase
   logic setup; // setup phase
   logic ctrl_sel; // indirect port maps control
   logic busy_any; // any cycle running
   logic start_rd; // launch a read
   logic start_wr; // launch a write
   logic mapped; // address known
   logic [7:0] ctrl_view; // control register image
   nv_mem_if #(.AW(NV_AW), .DW(NV_DW)) mif ();
   // bus phases
   assign wr_acc = psel & penable & pwrite;
   assign setup = psel & ~penable;
   // control register only behind pointer and bank
   assign ctrl_sel = (bank_select == CTRL_BANK_VAL) &&
      (indirect_pointer == CTRL_PTR_VAL); // [R17]
   // no new strobe while a cycle runs
   assign busy_any = mif.busy | rd_strobe | wr_strobe; // [R21]
   // read needs read_allow already set
   assign start_rd = wr_acc && paddr == OFS_PORT && ctrl_sel &&
      pwdata[BIT_RD] && !pwdata[BIT_WR] && read_allow &&
      !busy_any; // [R1] [R2] [R21]
   // write needs write_allow already set
   assign start_wr = wr_acc && paddr == OFS_PORT && ctrl_sel &&
      pwdata[BIT_WR] && write_allow && !busy_any; // [R8] [R21]
   // ===========================================================
   // store interface
   assign mif.rd_go = start_rd;
   assign mif.wr_go = start_wr;
   assign mif.addr = nv_addr_reg;
   assign mif.wdata = nv_data_reg;
   // array and cycle timers
   nv_store #(.DEPTH(DEPTH), .RD_CYC(READ_CYCLES),
      .WR_CYC(WR_CYC)) u_store
   (
      .pclk(pclk),
      .presetn(presetn),
      .m(mif.mem)
   );
   // ===========================================================
   // control image: four bits, upper bits zero
   assign ctrl_view = {4'h0, write_allow, wr_strobe, read_allow,
      rd_strobe}; // [R20]
   // known addresses
   always_comb
   begin
      unique case (paddr)
         OFS_ADDR, OFS_DATA, OFS_BANK, OFS_PTR, OFS_PORT,
         OFS_IRQ_EN, OFS_IRQ_FLAG: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end
   // ===========================================================
   // next register values
   always_comb
   begin
      next_addr = nv_addr_reg;
      next_data = nv_data_reg;
      next_bank = bank_select;
      next_ptr = indirect_pointer;
      next_write_allow = write_allow;
      next_read_allow = read_allow;
      next_nv_en = nv_irq_allow;
      next_mf_en = mf_irq_allow;
      next_glb = global_irq_allow;
      next_nv_flag = nv_irq_flag;
      next_mf_flag = mf_irq_flag;
      // software writes
      if (wr_acc)
      begin
         unique case (paddr)
            OFS_ADDR: next_addr = pwdata[NV_AW-1:0]; // [R19]
            OFS_DATA: next_data = pwdata[NV_DW-1:0];
            OFS_BANK: next_bank = pwdata[7:0];
            OFS_PTR: next_ptr = pwdata[7:0];
            OFS_PORT:
            begin
               // allow bits only through the indirect path
               if (ctrl_sel)
               begin
                  next_write_allow = pwdata[BIT_WRITE_ALLOW];
                  next_read_allow = pwdata[BIT_READ_ALLOW];
               end
            end
            OFS_IRQ_EN:
            begin
               next_nv_en = pwdata[EN_NV];
               next_mf_en = pwdata[EN_MF];
               next_glb = pwdata[EN_GLB];
            end
            OFS_IRQ_FLAG:
            begin
               next_nv_flag = pwdata[FLAG_NV];
               next_mf_flag = pwdata[FLAG_MF];
            end
            default: ;
         endcase
      end
      // fetched byte wins over a software write
      if (mif.rd_done)
         next_data = mif.rdata; // [R5]
      // service clears only the multi-function flag
      if (irq_ack)
         next_mf_flag = 1'b0; // [R15]
      // write end sets both flags, set wins over clear
      if (mif.wr_done)
      begin
         next_nv_flag = 1'b1; // [R13]
         next_mf_flag = 1'b1; // [R13]
      end
      // strobes set by launch, cleared by hardware only
      next_rd = start_rd ? 1'b1 :
         (mif.rd_done ? 1'b0 : rd_strobe); // [R1]
      next_wr = start_wr ? 1'b1 :
         (mif.wr_done ? 1'b0 : wr_strobe); // [R9] [R10]
      // read data captured in the setup phase
      next_prdata = prdata;
      if (setup)
      begin
         unique case (paddr)
            OFS_ADDR: next_prdata = {26'h000_0000, nv_addr_reg};
            OFS_DATA: next_prdata = {24'h00_0000, nv_data_reg};
            OFS_BANK: next_prdata = {24'h00_0000, bank_select};
            OFS_PTR: next_prdata = {24'h00_0000, indirect_pointer};
            OFS_PORT: next_prdata = ctrl_sel ?
               {24'h00_0000, ctrl_view} : 32'h0000_0000;
            OFS_IRQ_EN: next_prdata = {29'h0000_0000,
               global_irq_allow, mf_irq_allow, nv_irq_allow};
            OFS_IRQ_FLAG: next_prdata = {30'h0000_0000,
               mf_irq_flag, nv_irq_flag};
            default: next_prdata = 32'h0000_0000;
         endcase
      end
   end
   // ===========================================================
   // registers: power-on clears every control bit
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         nv_addr_reg <= '0;
         nv_data_reg <= RST_BYTE;
         bank_select <= RST_BYTE; // [R12]
         indirect_pointer <= RST_BYTE;
         write_allow <= 1'b0; // [R11]
         wr_strobe <= 1'b0;
         read_allow <= 1'b0;
         rd_strobe <= 1'b0;
         nv_irq_allow <= 1'b0;
         mf_irq_allow <= 1'b0;
         global_irq_allow <= 1'b0;
         nv_irq_flag <= 1'b0;
         mf_irq_flag <= 1'b0;
         prdata <= 32'h0000_0000;
      end
      else
      begin
         nv_addr_reg <= next_addr;
         nv_data_reg <= next_data;
         bank_select <= next_bank;
         indirect_pointer <= next_ptr;
         write_allow <= next_write_allow;
         wr_strobe <= next_wr;
         read_allow <= next_read_allow;
         rd_strobe <= next_rd;
         nv_irq_allow <= next_nv_en;
         mf_irq_allow <= next_mf_en;
         global_irq_allow <= next_glb;
         nv_irq_flag <= next_nv_flag;
         mf_irq_flag <= next_mf_flag;
         prdata <= next_prdata;
      end
   end
   // ===========================================================
   // bus answers: no wait states, error on unknown address
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;
   // request needs all three enables and both flags
   assign irq_req = nv_irq_flag & mf_irq_flag & nv_irq_allow &
      mf_irq_allow & global_irq_allow; // [R14]
   // ===========================================================
   // checks
   localparam int RD_LIM = 6; // read must end by then
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // a read clears its own strobe within a few clocks
   read_ends_a: assert property ( // [R1] [R21]
      $rose(rd_strobe) |-> ##[1:RD_LIM] !rd_strobe)
      else $error("read strobe did not clear in time");
   // a read only starts when read_allow was already set
   read_gate_a: assert property ( // [R2]
      $rose(rd_strobe) |-> $past(read_allow))
      else $error("read started without read_allow");
   // the fetched byte is in the data register as the strobe drops
   data_hold_a: assert property ( // [R5]
      $fell(rd_strobe) |-> nv_data_reg == mif.rdata)
      else $error("fetched byte not in data register");
   // the read strobe only drops on the store's read end
   read_src_a: assert property ( // [R1]
      $fell(rd_strobe) |-> $past(mif.rd_done))
      else $error("read strobe dropped without read end");
   // a write only starts when write_allow was already set
   write_gate_a: assert property ( // [R8]
      $rose(wr_strobe) |-> $past(write_allow))
      else $error("write started without write_allow");
   // the write timer runs for a minimum time
   write_time_a: assert property ( // [R9]
      $rose(wr_strobe) |-> wr_strobe [*8])
      else $error("write cycle ended too soon");
   // write end raises both request flags
   write_end_a: assert property ( // [R10] [R13]
      $fell(wr_strobe) |-> nv_irq_flag && mf_irq_flag)
      else $error("write end did not raise both flags");
   // the write strobe only drops on the store's write end
   write_src_a: assert property ( // [R10]
      $fell(wr_strobe) |-> $past(mif.wr_done))
      else $error("write strobe dropped without write end");
   // no request while any enable is clear
   irq_gate_a: assert property ( // [R14]
      irq_req |-> global_irq_allow && mf_irq_allow && nv_irq_allow)
      else $error("interrupt raised while disabled");
   // write end with every enable set raises the request
   irq_raise_a: assert property ( // [R13] [R14]
      mif.wr_done && !wr_acc && nv_irq_allow && mf_irq_allow &&
      global_irq_allow |=> irq_req)
      else $error("write end raised no request");
   // service clears the multi-function flag and keeps the other
   ack_clear_a: assert property ( // [R15]
      irq_ack && !mif.wr_done && nv_irq_flag &&
      !(wr_acc && paddr == OFS_IRQ_FLAG) |=>
      !mf_irq_flag && nv_irq_flag)
      else $error("service cleared wrong flag");
   // no launch while a cycle runs
   busy_block_a: assert property ( // [R21]
      busy_any |-> !start_rd && !start_wr)
      else $error("strobe accepted while busy");
   // never a read and a write running together
   strobe_excl_a: assert property ( // [R21]
      !(rd_strobe && wr_strobe))
      else $error("read and write strobes both set");
   // port writes outside the control location leave allow bits
   ctrl_hidden_a: assert property ( // [R17]
      wr_acc && paddr == OFS_PORT && !ctrl_sel |=>
      $stable(write_allow) && $stable(read_allow))
      else $error("hidden control register changed");
   // address register reads back six bits
   addr_width_a: assert property ( // [R19]
      psel && !penable && paddr == OFS_ADDR |=>
      prdata[31:NV_AW] == '0)
      else $error("address upper bits not zero");
endmodule // nv_access_ctrl
`default_nettype wire

// ### bench/data_eeprom_access_control_bench.sv
// self-checking bench for the nonvolatile access control block
`timescale 1ns/1ns
`default_nettype none
module data_eeprom_access_control_bench
   import nv_pkg::*;
;
   // ============================================================
   // bench constants
   localparam int WR_T = 10; // shortened programming time
   localparam int MAX_CYC = 20000; // hang limit in clocks
   // ============================================================
   // signals
   logic pclk; // system clock
   logic presetn; // async reset, active low
   logic psel; // apb select
   logic penable; // apb access phase
   logic pwrite; // apb direction
   logic [7:0] paddr; // apb address
   logic [31:0] pwdata; // apb write data
   logic [31:0] prdata; // apb read data
   logic pready; // apb ready
   logic pslverr; // apb error
   logic irq_ack; // service pulse
   logic irq_req; // interrupt request
   int num_errors; // mismatches seen
   int checked; // comparisons made
   int cyc; // clocks since start
   logic [31:0] rd; // last read word
   logic er; // last error flag
   logic [7:0] mem_exp [64]; // bench image of the store
   // ============================================================
   // device under test
   nv_access_ctrl #(.DEPTH(64), .WR_CYC(WR_T)) dut_u (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .irq_ack(irq_ack),
      .irq_req(irq_req));
   // ============================================================
   // expectation functions
   // request level from flags and enables
   function automatic logic exp_irq(input logic [1:0] f,
      input logic [2:0] e);
      return f[FLAG_NV] & f[FLAG_MF] & e[EN_NV] & e[EN_MF] & e[EN_GLB];
   endfunction
   // address register keeps six bits only
   function automatic logic [31:0] exp_addr(input logic [31:0] d);
      return d & 32'h0000_003F;
   endfunction
   // ============================================================
   // reporting
   task automatic finish_test();
      if (num_errors == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // compare a word
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp,
      input string msg);
      checked++;
      if (got !== exp)
      begin
         num_errors++;
         $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   // compare a single bit
   task automatic chk_bit(input logic got, input logic exp, input string msg);
      checked++;
      if (got !== exp)
      begin
         num_errors++;
         $display("MISMATCH %0t %s got %b exp %b", $time, msg, got, exp);
      end
   endtask
   // ============================================================
   // apb master: setup, access until pready, then release
   task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // this wait ends once pready is high, or on the hang guard
      while (pready !== 1'b1)
         @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rreg(input logic [7:0] a);
      apb(1'b0, a, 32'h0000_0000);
   endtask
   // ============================================================
   // store access sequences
   // full write: address, data, allow, strobe, poll for the end
   task automatic do_write(input logic [5:0] a, input logic [7:0] d);
      time t0;
      int n;
      wreg(OFS_ADDR, {26'h0, a});
      wreg(OFS_DATA, {24'h0, d});
      wreg(OFS_IRQ_EN, 32'h0000_0003);
      wreg(OFS_PORT, 32'h0000_0008);
      wreg(OFS_PORT, 32'h0000_000C);
      t0 = $time;
      wreg(OFS_IRQ_EN, 32'h0000_0007);
      mem_exp[a] = d;
      rreg(OFS_PORT);
      chk_word(rd, 32'h0000_000C, "write running");
      n = 0;
      while (rd[BIT_WR] !== 1'b0 && n < 40)
      begin
         rreg(OFS_PORT);
         n++;
      end
      chk_bit(rd[BIT_WR], 1'b0, "write strobe clear");
      n = int'(($time - t0) / CLK_PERIOD_NS);
      chk_bit(n >= WR_T + 2 && n <= WR_T + 8, 1'b1, "write time");
      rreg(OFS_IRQ_FLAG);
      chk_word(rd, 32'h0000_0003, "flags at write end");
      wreg(OFS_PORT, 32'h0000_0000);
   endtask
   // full read: allow, address, strobe, poll, fetch the byte
   task automatic do_read(input logic [5:0] a);
      time t0;
      int n;
      wreg(OFS_PORT, 32'h0000_0002);
      wreg(OFS_ADDR, {26'h0, a});
      wreg(OFS_PORT, 32'h0000_0003);
      t0 = $time;
      n = 0;
      rd = 32'h0000_0001;
      while (rd[BIT_RD] !== 1'b0 && n < 20)
      begin
         rreg(OFS_PORT);
         n++;
      end
      chk_bit(rd[BIT_RD], 1'b0, "read strobe clear");
      n = int'(($time - t0) / CLK_PERIOD_NS);
      chk_bit(n <= 12, 1'b1, "read bounded");
      rreg(OFS_DATA);
      chk_word(rd, {24'h0, mem_exp[a]}, "read byte");
      wreg(OFS_PORT, 32'h0000_0000);
   endtask
   // ============================================================
   // clock generator
   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // hang guard
   always @(posedge pclk)
   begin
      cyc <= cyc + 1;
      if (cyc >= MAX_CYC)
      begin
         num_errors++;
         finish_test();
      end
   end
   // ============================================================
   // main sequence
   initial
   begin
      logic [7:0] d;
      logic [5:0] a;
      logic [7:0] offs [6];
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      irq_ack = 1'b0;
      num_errors = 0;
      checked = 0;
      offs = '{OFS_ADDR, OFS_DATA, OFS_BANK, OFS_PTR, OFS_IRQ_EN,
         OFS_IRQ_FLAG};
      void'($urandom(46));
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      // reset values of every direct register
      foreach (offs[i])
      begin
         rreg(offs[i]);
         chk_word(rd, 32'h0000_0000, "reset value");
      end
      // control unreachable while the first bank is selected
      rreg(OFS_PORT);
      chk_word(rd, 32'h0000_0000, "port with bank 0");
      rreg(8'h1C);
      chk_bit(er, 1'b1, "unmapped error");
      // address keeps six bits
      wreg(OFS_ADDR, 32'h0000_00FF);
      rreg(OFS_ADDR);
      chk_word(rd, exp_addr(32'h0000_00FF), "address width");
      // wrong pointer hides control, right one shows it
      wreg(OFS_BANK, {24'h0, CTRL_BANK_VAL});
      wreg(OFS_PTR, 32'h0000_0041);
      wreg(OFS_PORT, 32'h0000_0002);
      wreg(OFS_PTR, {24'h0, CTRL_PTR_VAL});
      rreg(OFS_PORT);
      chk_word(rd, 32'h0000_0000, "wrong pointer");
      wreg(OFS_PORT, 32'h0000_00F0);
      rreg(OFS_PORT);
      chk_word(rd, 32'h0000_0000, "upper control bits");
      // strobes without prior allow are ignored
      wreg(OFS_PORT, 32'h0000_0004);
      rreg(OFS_PORT);
      chk_word(rd, 32'h0000_0000, "write strobe alone");
      wreg(OFS_PORT, 32'h0000_000C);
      rreg(OFS_PORT);
      chk_word(rd, 32'h0000_0008, "allow and strobe at once");
      wreg(OFS_PORT, 32'h0000_0000);
      wreg(OFS_DATA, 32'h0000_005A);
      wreg(OFS_PORT, 32'h0000_0001);
      rreg(OFS_PORT);
      chk_word(rd, 32'h0000_0000, "read strobe alone");
      rreg(OFS_DATA);
      chk_word(rd, 32'h0000_005A, "data kept");
      // writes and read-backs, end addresses first then random
      for (int i = 0; i < 6; i++)
      begin
         a = (i == 0) ? 6'h00 : (i == 1) ? 6'h3F : 6'($urandom % 64);
         d = 8'($urandom);
         do_write(a, d);
         wreg(OFS_IRQ_FLAG, 32'h0000_0000);
         do_read(a);
      end
      // interrupt: each enable alone masks the request
      do_write(6'h15, 8'hA5);
      for (int k = 0; k < 3; k++)
      begin
         wreg(OFS_IRQ_EN, 32'h0000_0007 & ~(32'h1 << k));
         @(negedge pclk);
         chk_bit(irq_req, exp_irq(2'b11, 3'(~(1 << k))), "masked");
      end
      wreg(OFS_IRQ_EN, 32'h0000_0007);
      @(negedge pclk);
      chk_bit(irq_req, exp_irq(2'b11, 3'b111), "request");
      @(posedge pclk);
      irq_ack <= 1'b1;
      @(posedge pclk);
      irq_ack <= 1'b0;
      rreg(OFS_IRQ_FLAG);
      chk_word(rd, 32'h0000_0001, "ack clears multi flag only");
      chk_bit(irq_req, exp_irq(2'b01, 3'b111), "request after ack");
      // reset in mid-run clears allow and bank
      wreg(OFS_PORT, 32'h0000_0008);
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rreg(OFS_BANK);
      chk_word(rd, 32'h0000_0000, "bank after reset");
      wreg(OFS_BANK, {24'h0, CTRL_BANK_VAL});
      wreg(OFS_PTR, {24'h0, CTRL_PTR_VAL});
      rreg(OFS_PORT);
      chk_word(rd, 32'h0000_0000, "allow after reset");
      finish_test();
   end
endmodule // data_eeprom_access_control_bench
`default_nettype wire
